// ===== hw/hscp_pkg.sv
package hscp_pkg;

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  localparam int         BYTE_BITS        = 8;
  localparam int         MAX_PACKET_BYTES = 32;
  localparam logic [5:0] PACKET_LIMIT     = 6'h20;
  localparam logic [2:0] LAST_BIT_INDEX   = 3'h7;

  // ----------------------------------------------------------------
  // Field counts for init wait and lockouts
  // ----------------------------------------------------------------
  localparam int         FIELD_CNT_W       = 9;
  localparam logic [8:0] INIT_FIELDS       = 9'h00A;
  localparam logic [8:0] EE_WRITE_FIELDS   = 9'h012;
  localparam logic [8:0] EE_ALL_FIELDS     = 9'h168;

  // ----------------------------------------------------------------
  // Reset values and strap timing
  // ----------------------------------------------------------------
  localparam logic [1:0] SYNC_RESET        = 2'h0;
  localparam logic [1:0] STRAP_SETTLE      = 2'h3;

  typedef enum logic [1:0] {
    CMD_PLAIN        = 2'b00,
    CMD_REG_WRITE    = 2'b01,
    CMD_EE_WRITE     = 2'b10,
    CMD_EE_WRITE_ALL = 2'b11
  } cmd_class_e;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_APPLY = 3'b011,
    ST_LOCK  = 3'b100,
    ST_OFF   = 3'b101
  } port_state_e;

  // Edge finders on synchronised levels
  function automatic logic rise_of(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction : rise_of

  function automatic logic fall_of(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fall_of

endpackage : hscp_pkg

// ===== hw/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if

// ===== hw/byte_skid_fifo.sv
`timescale 1ns/1ps
module byte_skid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,     // System clock
  input  wire logic             rst_n,     // Sync reset, active low
  byte_stream_if.sink           in_s,      // Filling side
  output logic [WIDTH-1:0]      out_data,  // Oldest entry
  output logic                  out_valid, // Entry available
  input  wire logic             out_ready  // Drain side accepts
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  // Handshakes; ready falls only when truly full
  assign in_s.ready = (count != CW'(DEPTH));
  assign out_valid  = (count != '0);
  assign out_data   = mem[rd_ptr];
  assign push       = in_s.valid & in_s.ready;
  assign pop        = out_valid & out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

endmodule : byte_skid_fifo

// ===== hw/host_serial_command_port.sv
`timescale 1ns/1ps
// What this block does
// - Host-port select strap is caught once after reset; later changes need reset.
// - With select low, input bits are taken on rising serial clock into bytes.
// - Output bit changes on each falling serial clock edge.
// - Every byte travels least significant bit first, both directions.
// - Output pin keeps its last level once a transfer ends.
// - Packets hold at most 32 bytes; whole packet taken, then executed.
// - New commands are refused until the current one has finished.
// - Reply to a packet is shifted out during the following packet.
// - Command latched only when select returns high.
// - Register writes take effect at next vertical drive latch point.
// - Only the staged register apply waits for the forbidden-communication window; packets latch at any time.
// - After a memory write, commands are refused for 18 fields.
// - After a write-all-categories command, commands are refused for 360 fields.
module host_serial_command_port (
  input  wire logic                clock,                // 10 MHz system clock
  input  wire logic                rst_n,                // Sync reset, active low
  input  wire logic                host_port_select,     // Strap, low picks host port
  input  wire logic                port_select_n,        // Chip select pin
  input  wire logic                serial_clock,         // Host serial clock pin
  input  wire logic                serial_in,            // Host data pin
  output logic                     serial_out,           // Reply data pin
  input  wire logic                vertical_drive_pulse, // Field pulse
  input  wire logic [7:0]          resp_data,            // Next reply byte
  output logic                     resp_take,            // Reply byte loaded
  output logic [4:0]               resp_index,           // Byte slot being loaded
  output logic [7:0]               rx_data,              // Received byte
  output logic                     rx_valid,             // Byte available
  input  wire logic                rx_ready,             // Byte consumer ready
  output logic                     rx_overrun,           // Byte lost this packet
  output logic                     pkt_done,             // Packet closed
  output logic [5:0]               pkt_len,              // Bytes in packet
  input  wire hscp_pkg::cmd_class_e cmd_class,           // Class of closed packet
  input  wire logic                exec_done,            // Command finished
  output logic                     apply_strobe,         // Apply staged registers
  output logic                     port_open             // Accepting packets
);
  import hscp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_sync, sck_sync, si_sync, vd_sync, sel_sync;
  logic       cs_q, sck_q, vd_q;

  // Two stages for every pin; only stage 1 feeds logic
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h3;
      si_sync  <= SYNC_RESET;
      vd_sync  <= SYNC_RESET;
      sel_sync <= SYNC_RESET;
    end else begin
      cs_sync  <= {cs_sync[0], port_select_n};
      sck_sync <= {sck_sync[0], serial_clock};
      si_sync  <= {si_sync[0], serial_in};
      vd_sync  <= {vd_sync[0], vertical_drive_pulse};
      sel_sync <= {sel_sync[0], host_port_select};
    end
  end

  // Previous levels for edge finding
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_q  <= 1'b1;
      sck_q <= 1'b1;
      vd_q  <= 1'b0;
    end else begin
      cs_q  <= cs_sync[1];
      sck_q <= sck_sync[1];
      vd_q  <= vd_sync[1];
    end
  end

  logic cs_fall, cs_rise, sck_rise, sck_fall, vd_fall;
  assign cs_fall  = fall_of(cs_q, cs_sync[1]);
  assign cs_rise  = rise_of(cs_q, cs_sync[1]);
  assign sck_rise = rise_of(sck_q, sck_sync[1]);
  assign sck_fall = fall_of(sck_q, sck_sync[1]);
  assign vd_fall  = fall_of(vd_q, vd_sync[1]);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  logic [1:0] strap_wait;
  logic       use_host;

  // Wait for the synchroniser to fill, then freeze the choice
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_wait <= 2'h0;
      use_host   <= 1'b0;
    end else if (strap_wait != STRAP_SETTLE) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == STRAP_SETTLE - 2'h1) begin
        use_host <= ~sel_sync[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  port_state_e            state;
  cmd_class_e             class_q;
  logic [FIELD_CNT_W-1:0] field_cnt;
  logic [FIELD_CNT_W-1:0] lock_limit;
  logic                   rx_open;
  logic [5:0]             byte_cnt;
  logic                   pkt_end;

  assign pkt_end   = cs_rise & rx_open & (byte_cnt != 6'h00);
  assign port_open = (state == ST_IDLE);

  // Init wait, execution, staged apply and field lockouts
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state        <= ST_INIT;
      class_q      <= CMD_PLAIN;
      field_cnt    <= '0;
      lock_limit   <= '0;
      pkt_done     <= 1'b0;
      pkt_len      <= 6'h00;
      apply_strobe <= 1'b0;
    end else begin
      pkt_done     <= 1'b0;
      apply_strobe <= 1'b0;
      case (state)
        ST_INIT: begin
          if (vd_fall && strap_wait == STRAP_SETTLE) begin
            field_cnt <= field_cnt + 1'b1;
            if (field_cnt + 1'b1 == INIT_FIELDS) begin
              state <= use_host ? ST_IDLE : ST_OFF;
            end
          end
        end
        ST_IDLE: begin
          if (pkt_end) begin
            pkt_done <= 1'b1;
            pkt_len  <= byte_cnt;
            class_q  <= cmd_class;
            state    <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            field_cnt <= '0;
            case (class_q)
              CMD_REG_WRITE:    state <= ST_APPLY;
              CMD_EE_WRITE: begin
                lock_limit <= EE_WRITE_FIELDS;
                state      <= ST_LOCK;
              end
              CMD_EE_WRITE_ALL: begin
                lock_limit <= EE_ALL_FIELDS;
                state      <= ST_LOCK;
              end
              default:          state <= ST_IDLE;
            endcase
          end
        end
        ST_APPLY: begin
          // Vertical drive fall opens the quiet window
          if (vd_fall) begin
            apply_strobe <= 1'b1;
            state        <= ST_IDLE;
          end
        end
        ST_LOCK: begin
          if (vd_fall) begin
            field_cnt <= field_cnt + 1'b1;
            if (field_cnt + 1'b1 == lock_limit) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic [7:0] pend_data;
  logic       pend_valid;
  logic       byte_done;
  byte_stream_if #(.WIDTH(BYTE_BITS)) to_fifo ();

  // Packet opens only while idle; busy packets are ignored whole
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_open  <= 1'b0;
      rx_shift <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 6'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (cs_fall) begin
        rx_open  <= (state == ST_IDLE);
        bit_cnt  <= 3'h0;
        byte_cnt <= 6'h00;
      end else if (cs_rise) begin
        rx_open <= 1'b0;
        bit_cnt <= 3'h0;
      end else if (rx_open && sck_rise) begin
        rx_shift <= {si_sync[1], rx_shift[7:1]};
        bit_cnt  <= bit_cnt + 3'h1;
        if (bit_cnt == LAST_BIT_INDEX && byte_cnt != PACKET_LIMIT) begin
          byte_cnt  <= byte_cnt + 6'h01;
          byte_done <= 1'b1;
        end
      end
    end
  end

  // Holding slot in front of the buffer; a lost byte is flagged
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_data  <= 8'h00;
      rx_overrun <= 1'b0;
    end else begin
      if (byte_done && (!pend_valid || to_fifo.ready)) begin
        pend_valid <= 1'b1;
        pend_data  <= rx_shift;
      end else if (to_fifo.ready) begin
        pend_valid <= 1'b0;
      end
      if (byte_done && pend_valid && !to_fifo.ready) begin
        rx_overrun <= 1'b1;
      end else if (cs_fall) begin
        rx_overrun <= 1'b0;
      end
    end
  end

  assign to_fifo.data  = pend_data;
  assign to_fifo.valid = pend_valid;

  byte_skid_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (2)
  ) u_rx_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_s      (to_fifo),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // ----------------------------------------------------------------
  // Reply shifter
  // ----------------------------------------------------------------
  logic [6:0] tx_shift;

  // First fall of a byte loads the reply; pin holds level when idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      serial_out <= 1'b1;
      tx_shift   <= 7'h00;
      resp_take  <= 1'b0;
      resp_index <= 5'h00;
    end else begin
      resp_take <= 1'b0;
      if (rx_open && sck_fall) begin
        if (bit_cnt == 3'h0) begin
          serial_out <= resp_data[0];
          tx_shift   <= resp_data[7:1];
          resp_take  <= (byte_cnt != PACKET_LIMIT);
          resp_index <= byte_cnt[4:0];
        end else begin
          serial_out <= tx_shift[0];
          tx_shift   <= {1'b0, tx_shift[6:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_packet_length: assert property (pkt_done |-> pkt_len != 6'h00 && pkt_len <= PACKET_LIMIT)
    else $error("packet length out of range");
  chk_busy_refuse: assert property (state != ST_IDLE && cs_fall |=> !rx_open)
    else $error("packet opened while busy");
  chk_output_hold: assert property (!rx_open |=> $stable(serial_out))
    else $error("serial output moved outside a transfer");
  chk_rise_sample: assert property (byte_done |-> $past(sck_rise) && $past(bit_cnt) == LAST_BIT_INDEX)
    else $error("byte finished without rising clock");
  chk_fall_drive: assert property ($changed(serial_out) |-> $past(sck_fall) && $past(rx_open))
    else $error("serial output changed off a falling edge");
  chk_lsb_first: assert property (byte_done |-> rx_shift[7] == $past(si_sync[1]))
    else $error("last bit not in top position");
  chk_end_latch: assert property (pkt_done |-> $past(cs_rise) && $past(state) == ST_IDLE)
    else $error("command latched without select rising");
  chk_apply_field: assert property (apply_strobe |-> $past(vd_fall) && $past(state) == ST_APPLY)
    else $error("apply not on vertical drive fall");
  chk_lock_bound: assert property (state == ST_LOCK |-> field_cnt < lock_limit)
    else $error("lockout count overran its limit");
  chk_init_quiet: assert property (state == ST_INIT |-> !pkt_done && !rx_open)
    else $error("traffic taken during init period");

  cov_packet:  cover property (pkt_done);
  cov_apply:   cover property (apply_strobe);
  cov_lockout: cover property (state == ST_LOCK && vd_fall);
  cov_overrun: cover property ($rose(rx_overrun));

endmodule : host_serial_command_port

// ===== tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  output logic      serial_clock,  // Link clock, idle high
  output logic      port_select_n, // Select, active low
  output logic      serial_in,     // Data to device
  input  wire logic serial_out     // Reply from device
);
  logic [7:0] replies[$];          // Reply bytes of the last frame

  // Idle pins; the link clock stands still high outside frames
  initial begin
    serial_clock  = 1'b1;
    port_select_n = 1'b1;
    serial_in     = 1'b0;
  end

  // Whole bytes, then a partial byte of extra bits; byte k is seed plus 19 per byte
  // Bench link clock is scaled to 800 ns so fields stay short
  // Host reaches any shared memory itself; this model never asks the port to
  task automatic frame(input logic [7:0] seed, input int nbytes, input int extra);
    logic [7:0] tx;
    logic [7:0] rx;
    replies.delete();
    #37 port_select_n = 1'b0; // Clock already high when select falls
    #400;
    for (int k = 0; k <= nbytes; k++) begin
      tx = seed + 8'(k * 19);
      for (int i = 0; i < ((k < nbytes) ? 8 : extra); i++) begin
        serial_clock = 1'b0;
        serial_in    = tx[i]; // Low bit goes first
        #400;
        serial_clock = 1'b1;
        #399;
        rx[i] = serial_out; // Taken late, just before the next fall
        #1;
      end
      if (k < nbytes) replies.push_back(rx);
      #800; // One full clock period between bytes
    end
    port_select_n = 1'b1;
    serial_in     = ~serial_in; // Released line must not show a stale level
  endtask : frame
endmodule : host_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hscp_pkg::*;

  typedef struct packed {
    logic [5:0] nb;
    cmd_class_e cls;
    logic [7:0] seed;
  } row_s;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic       clock;
  logic       rst_n     = 1'b0;
  logic       strap     = 1'b1;
  logic       vd        = 1'b0;
  logic       rx_ready  = 1'b1;
  logic       exec_done = 1'b0;
  logic       load      = 1'b0;
  logic       vd_en     = 1'b0;
  cmd_class_e cls       = CMD_PLAIN;
  logic [7:0] resp_data = 8'h00;
  logic [7:0] rseed     = 8'h00;
  logic [4:0] idx_exp   = 5'h00;
  logic       serial_clock, port_select_n, serial_in, serial_out, resp_take, rx_valid;
  logic       rx_overrun, pkt_done, apply_strobe, port_open;
  logic [4:0] resp_index;
  logic [7:0] rx_data;
  logic [5:0] pkt_len;
  int         errors, tests_run, fields, takes;
  logic [7:0] rxq[$];
  row_s       rows[4] = '{'{6'h01, CMD_PLAIN, 8'h3A}, '{6'h02, CMD_REG_WRITE, 8'hC3},
                          '{6'h03, CMD_EE_WRITE, 8'h7E}, '{6'h04, CMD_EE_WRITE_ALL, 8'hE1}};

  host_model host (.serial_clock, .port_select_n, .serial_in, .serial_out);

  host_serial_command_port DUT (
    .clock, .rst_n, .host_port_select (strap), .port_select_n, .serial_clock, .serial_in, .serial_out,
    .vertical_drive_pulse (vd), .resp_data, .resp_take, .resp_index, .rx_data, .rx_valid, .rx_ready,
    .rx_overrun, .pkt_done, .pkt_len, .cmd_class (cls), .exec_done, .apply_strobe, .port_open
  );

  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Short fields keep the 360-field lockout cheap: high 8, low 12 cycles
  always begin
    @(posedge clock);
    if (vd_en) begin
      vd <= 1'b1;
      repeat (8) @(posedge clock);
      vd <= 1'b0;
      fields++;
      repeat (11) @(posedge clock);
    end
  end

  // Reply slots step by 60; popped bytes kept for comparison
  always @(posedge clock) begin
    if (load) begin
      resp_data <= rseed;
      idx_exp   <= 5'h00;
      takes     <= 0;
    end else if (resp_take === 1'b1) begin
      check_val("resp_index", {3'h0, idx_exp}, {3'h0, resp_index});
      resp_data <= resp_data + 8'h3C;
      idx_exp   <= idx_exp + 5'h01;
      takes     <= takes + 1;
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_val(what, {7'h00, exp}, {7'h00, got});
  endtask : check_bit

  function automatic logic sig(input int w);
    case (w)
      0: return pkt_done;
      1: return apply_strobe;
      default: return port_open;
    endcase
  endfunction : sig

  // Bounded wait for a one-cycle pulse or a level, then check it
  task automatic await(input int w, input int n, input string what);
    for (int i = 0; i < n && sig(w) !== 1'b1; i++) tick();
    check_bit(what, 1'b1, sig(w));
  endtask : await

  // Port stays shut and nothing is applied until n more fields have fallen
  task automatic hold_closed(input int n);
    int   start;
    logic ok;
    start = fields;
    ok    = 1'b1;
    while (fields < start + n) begin
      tick();
      ok = ok & (port_open === 1'b0) & (apply_strobe === 1'b0);
    end
    check_bit("closed", 1'b1, ok);
  endtask : hold_closed

  // Field pulse parked during reset so no fall lands near strap capture
  task automatic do_reset(input logic pin);
    @(posedge clock);
    vd_en <= 1'b0;
    repeat (24) @(posedge clock);
    rst_n <= 1'b0;
    strap <= pin;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    vd_en <= 1'b1;
  endtask : do_reset

  // Finish the command well away from a field fall, then follow its lockout
  task automatic finish_cmd(input cmd_class_e c);
    int nf;
    nf = fields;
    while (fields == nf) tick();
    repeat (5) @(posedge clock);
    exec_done <= 1'b1;
    @(posedge clock);
    exec_done <= 1'b0;
    nf = (c == CMD_PLAIN) ? 0 : (c == CMD_REG_WRITE) ? 1 : (c == CMD_EE_WRITE) ? 18 : 360;
    hold_closed(nf);
    if (c == CMD_REG_WRITE) await(1, 8, "apply_strobe");
    await(2, 8, "port_open");
  endtask : finish_cmd

  // One packet; len is the expected byte count, nrx the bytes popped meanwhile
  task automatic run(input int nb, input int extra, input cmd_class_e c, input logic [7:0] seed,
                     input int len, input int nrx);
    logic [7:0] r0;
    r0 = seed ^ 8'hFF;
    @(posedge clock);
    cls   <= c;
    rseed <= r0;
    load  <= 1'b1;
    @(posedge clock);
    load  <= 1'b0;
    rxq.delete();
    host.frame(seed, nb, extra);
    await(0, 12, "pkt_done");
    check_val("pkt_len", 8'(len), {2'b00, pkt_len});
    check_bit("port_busy", 1'b0, port_open);
    check_val("rx_count", 8'(nrx), 8'(rxq.size()));
    foreach (rxq[k]) check_val("rx_data", seed + 8'(k * 19), rxq[k]);
    foreach (host.replies[k]) if (k < 32) check_val("reply", r0 + 8'(k * 60), host.replies[k]);
    if (extra == 0 && nb > 0 && nb <= 32) begin
      r0 = r0 + 8'((nb - 1) * 60);
      repeat (30) tick();
      check_bit("serial_out_hold", r0[7], serial_out);
    end
  endtask : run

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    logic seen;
    do_reset(1'b1);
    hold_closed(12);
    @(posedge clock);
    strap <= 1'b0;
    hold_closed(3);
    $display("test strap done");
    do_reset(1'b0);
    hold_closed(10);
    await(2, 8, "port_open");
    $display("test init done");
    foreach (rows[r]) begin
      run(rows[r].nb, 0, rows[r].cls, rows[r].seed, rows[r].nb, rows[r].nb);
      finish_cmd(rows[r].cls);
      $display("test row %0d done", r);
    end
    // A frame sent while the command runs is ignored whole
    run(1, 0, CMD_PLAIN, 8'h21, 1, 1);
    rxq.delete();
    host.frame(8'h44, 2, 0);
    seen = 1'b0;
    repeat (12) begin
      tick();
      seen = seen | pkt_done;
    end
    check_bit("refused_done", 1'b0, seen);
    check_val("refused_rx", 8'h00, 8'(rxq.size()));
    check_val("refused_take", 8'h01, 8'(takes));
    finish_cmd(CMD_PLAIN);
    $display("test refused done");
    run(33, 0, CMD_PLAIN, 8'h90, 32, 32);
    finish_cmd(CMD_PLAIN);
    $display("test long done");
    // Consumer stalls: buffer fills, two bytes are lost, then it drains empty
    @(posedge clock);
    rx_ready <= 1'b0;
    run(5, 0, CMD_PLAIN, 8'h05, 5, 0);
    check_bit("rx_overrun", 1'b1, rx_overrun);
    @(posedge clock);
    rx_ready <= 1'b1;
    repeat (6) tick();
    check_val("drained_first", 8'h05, rxq[0]);
    check_bit("rx_empty", 1'b0, rx_valid);
    finish_cmd(CMD_PLAIN);
    $display("test stall done");
    run(2, 3, CMD_PLAIN, 8'h61, 2, 2);
    check_bit("overrun_cleared", 1'b0, rx_overrun);
    finish_cmd(CMD_PLAIN);
    $display("test partial done");
    complete_run();
  end

  // Whole run needs about 1.3 ms
  initial begin
    #3_000_000;
    errors++;
    $display("[FAIL] watchdog expected end seen timeout");
    complete_run();
  end
endmodule : tb_top
